// *** smst_core.sv ***
// SMART data page, threshold page and autosave command logic
//
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "smst_defs.svh"
module smst_core
(
	// Clock and reset
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	// Wishbone slave
	input  wire logic              cyc_i,
	input  wire logic              stb_i,
	input  wire logic              we_i,
	input  wire logic [7:0]        adr_i,
	input  wire logic [3:0]        sel_i,
	input  wire logic [31:0]       dat_i,
	output logic [31:0]            dat_o,
	output logic                   ack_o,
	// Host completion interrupt
	output logic                   intrq_o,
	// Attribute saving
	input  wire logic              mode_change_i,
	input  wire logic              normal_save_i,
	output logic                   attr_save_o,
	// Non-volatile autosave setting
	input  wire logic              nv_autosave_i,
	output smst_pkg::smst_nv_t     nv_o
);
	import smst_pkg::*;

	smst_state_t  state_reg;
	smst_status_t stat;
	logic         ack_reg;
	logic [31:0]  dat_reg;
	logic [7:0]   feat_reg;
	logic [7:0]   scnt_reg;
	logic [7:0]   snum_reg;
	logic [7:0]   trkl_reg;
	logic [7:0]   trkh_reg;
	logic [7:0]   unit_reg;
	logic [7:0]   err_reg;
	logic         err_flag_reg;
	logic         drq_reg;
	logic         irq_pend_reg;
	logic         intrq_reg;
	logic [7:0]   test_reg;
	logic [7:0]   offl_reg;
	logic [15:0]  ttime_reg;
	logic [7:0]   chkpt_reg;
	logic [15:0]  poll_reg;
	logic [1:0]   caps_reg;
	logic         asave_reg;
	logic [15:0]  thr_mem [0:`SMST_N_ENT-1];
	logic [7:0]   buf_mem [0:511];
	logic         thr_page_reg;
	logic [8:0]   idx_reg;
	logic [3:0]   ofs_reg;
	logic [4:0]   ent_reg;
	logic [7:0]   sum_reg;
	logic [7:0]   byte_next;
	logic [7:0]   rd_ptr_reg;
	logic         nv_s1_reg;
	logic         nv_s2_reg;
	logic [1:0]   nv_cnt_reg;
	logic         nv_wr_reg;
	logic         save_reg;
	logic         wr_go;
	logic         rd_go;
	logic         busy;
	logic [7:0]   test_byte;
	logic [3:0]   test_code;
	logic [3:0]   test_rem;
	logic [7:0]   wb_byte;
	logic [5:0]   thr_sel;
	logic         thr_hit;

	assign wr_go   = cyc_i && stb_i && we_i && ack_reg;
	assign rd_go   = cyc_i && stb_i && !we_i && ack_reg;
	assign wb_byte = dat_i[7:0];
	assign busy    = (state_reg == SMST_FILL) || (state_reg == SMST_APPLY);
	assign thr_sel = 6'((adr_i - `SMST_A_THR0) >> 2);
	assign thr_hit = (adr_i >= `SMST_A_THR0) && (adr_i <= `SMST_A_THRN)
		&& (adr_i[1:0] == 2'b00);

	assign stat = '{busy: busy, ready: !busy, drq: drq_reg,
		err: err_flag_reg, default: '0};

	// Codes 8..14 never leave the device; unknown ones read as fatal
	always_comb
	begin
		test_code = test_reg[7:4];
		test_rem  = test_reg[3:0];
		if (test_code > `SMST_CODE_MAXOK && test_code != `SMST_CODE_RUN)
			test_code = `SMST_CODE_FATAL;
		if (test_rem > `SMST_REM_MAX)
			test_rem = `SMST_REM_MAX;
		if (test_code != `SMST_CODE_RUN)
			test_rem = 4'h0;
		test_byte = {test_code, test_rem};
	end

	// Bus answer one cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= cyc_i && stb_i && !ack_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_reg <= 32'h0000_0000;
		else if (cyc_i && stb_i && !we_i && !ack_reg)
		begin
			dat_reg <= 32'h0000_0000;
			case (adr_i)
				`SMST_A_DATA:
					if (drq_reg)
						dat_reg[15:0] <= {buf_mem[{rd_ptr_reg, 1'b1}],
							buf_mem[{rd_ptr_reg, 1'b0}]};
				`SMST_A_FEAT:  dat_reg[7:0]  <= err_reg;
				`SMST_A_SCNT:  dat_reg[7:0]  <= scnt_reg;
				`SMST_A_SNUM:  dat_reg[7:0]  <= snum_reg;
				`SMST_A_TRKL:  dat_reg[7:0]  <= trkl_reg;
				`SMST_A_TRKH:  dat_reg[7:0]  <= trkh_reg;
				`SMST_A_UNIT:  dat_reg[7:0]  <= unit_reg;
				`SMST_A_CMD:   dat_reg[7:0]  <= stat;
				`SMST_A_TEST:  dat_reg[7:0]  <= test_byte;
				`SMST_A_OFFL:  dat_reg[7:0]  <= offl_reg;
				`SMST_A_TTIME: dat_reg[15:0] <= ttime_reg;
				`SMST_A_CHKPT: dat_reg[7:0]  <= chkpt_reg;
				`SMST_A_POLL:  dat_reg[15:0] <= poll_reg;
				`SMST_A_CAPS:  dat_reg[1:0]  <= caps_reg;
				`SMST_A_ASAVE: dat_reg[0]    <= asave_reg;
				default:
					if (thr_hit)
						dat_reg[15:0] <= thr_mem[thr_sel[4:0]];
			endcase
		end
	end

	// Task-file registers; ignored while busy as the host must wait
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			feat_reg <= 8'h00;
			scnt_reg <= 8'h00;
			snum_reg <= 8'h00;
			trkl_reg <= 8'h00;
			trkh_reg <= 8'h00;
			unit_reg <= 8'h00;
		end
		else if (wr_go && sel_i[0] && !busy)
		begin
			case (adr_i)
				`SMST_A_FEAT: feat_reg <= wb_byte;
				`SMST_A_SCNT: scnt_reg <= wb_byte;
				`SMST_A_SNUM: snum_reg <= wb_byte;
				`SMST_A_TRKL: trkl_reg <= wb_byte;
				`SMST_A_TRKH: trkh_reg <= wb_byte;
				`SMST_A_UNIT: unit_reg <= wb_byte;
				default: ;
			endcase
		end
	end

	// Firmware-supplied page content
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			test_reg  <= 8'h00;
			offl_reg  <= 8'h00;
			ttime_reg <= 16'h0000;
			chkpt_reg <= 8'h00;
			poll_reg  <= 16'h0000;
			caps_reg  <= 2'h0;
		end
		else if (wr_go && sel_i[0])
		begin
			case (adr_i)
				`SMST_A_TEST:  test_reg  <= wb_byte;
				`SMST_A_OFFL:  offl_reg  <= wb_byte;
				`SMST_A_TTIME: ttime_reg <= dat_i[15:0];
				`SMST_A_CHKPT: chkpt_reg <= wb_byte;
				`SMST_A_POLL:  poll_reg  <= dat_i[15:0];
				`SMST_A_CAPS:  caps_reg  <= dat_i[1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (wr_go && thr_hit && sel_i[0])
			thr_mem[thr_sel[4:0]] <= dat_i[15:0];
	end

	// Page builder: one byte per cycle, checksum last
	always_comb
	begin
		byte_next = 8'h00;
		if (idx_reg == 9'd0)
			byte_next = `SMST_REV_LO;
		else if (idx_reg == 9'd1)
			byte_next = `SMST_REV_HI;
		else if (idx_reg == `SMST_B_LAST)
			byte_next = 8'h00 - sum_reg;
		else if (thr_page_reg)
		begin
			if (idx_reg <= `SMST_B_ENTN && ofs_reg == 4'd0)
				byte_next = thr_mem[ent_reg][7:0];
			else if (idx_reg <= `SMST_B_ENTN && ofs_reg == 4'd1)
				byte_next = thr_mem[ent_reg][15:8];
		end
		else
		begin
			case (idx_reg)
				`SMST_B_OFFL:   byte_next = offl_reg;
				`SMST_B_TEST:   byte_next = test_byte;
				`SMST_B_TTL:    byte_next = ttime_reg[7:0];
				`SMST_B_TTH:    byte_next = ttime_reg[15:8];
				`SMST_B_CAP:    byte_next = `SMST_CAP_FIXED
					| {5'h00, caps_reg[1], 2'b00};
				`SMST_B_SCAP:   byte_next = `SMST_SCAP_FIXED
					| {7'h00, caps_reg[0]};
				`SMST_B_ELOG:   byte_next = `SMST_ERRLOG;
				`SMST_B_CHK:    byte_next = chkpt_reg;
				`SMST_B_PSHORT: byte_next = poll_reg[7:0];
				`SMST_B_PEXT:   byte_next = poll_reg[15:8];
				default:        byte_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (state_reg == SMST_FILL)
			buf_mem[idx_reg] <= byte_next;
	end

	// Command sequencer
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg    <= SMST_IDLE;
			idx_reg      <= 9'd0;
			ofs_reg      <= 4'd0;
			ent_reg      <= 5'd0;
			sum_reg      <= 8'h00;
			thr_page_reg <= 1'b0;
			drq_reg      <= 1'b0;
			rd_ptr_reg   <= 8'h00;
			err_reg      <= 8'h00;
			err_flag_reg <= 1'b0;
			irq_pend_reg <= 1'b0;
		end
		else
		begin
			irq_pend_reg <= 1'b0;
			case (state_reg)
				SMST_IDLE:
					if (wr_go && sel_i[0] && adr_i == `SMST_A_CMD)
					begin
						err_reg      <= 8'h00;
						err_flag_reg <= 1'b0;
						idx_reg      <= 9'd0;
						ofs_reg      <= 4'd0;
						ent_reg      <= 5'd0;
						sum_reg      <= 8'h00;
						thr_page_reg <= feat_reg == `SMST_F_RTHR;
						if (wb_byte != `SMST_OPC
							|| trkh_reg != `SMST_SIG_H
							|| trkl_reg != `SMST_SIG_L
							|| !(feat_reg == `SMST_F_RDATA
							|| feat_reg == `SMST_F_RTHR
							|| feat_reg == `SMST_F_ASAVE))
						begin
							err_reg[`SMST_ABRT_BIT] <= 1'b1;
							err_flag_reg <= 1'b1;
							irq_pend_reg <= 1'b1;
						end
						else if (feat_reg == `SMST_F_ASAVE)
							state_reg <= SMST_APPLY;
						else
							state_reg <= SMST_FILL;
					end
				SMST_FILL:
				begin
					idx_reg <= idx_reg + 9'd1;
					sum_reg <= sum_reg + byte_next;
					if (idx_reg >= `SMST_B_ENT0 && ofs_reg == `SMST_ENT_LEN)
					begin
						ofs_reg <= 4'd0;
						ent_reg <= ent_reg + 5'd1;
					end
					else if (idx_reg >= `SMST_B_ENT0)
						ofs_reg <= ofs_reg + 4'd1;
					if (idx_reg == `SMST_B_LAST)
					begin
						state_reg    <= SMST_XFER;
						drq_reg      <= 1'b1;
						rd_ptr_reg   <= 8'h00;
						irq_pend_reg <= 1'b1;
					end
				end
				SMST_XFER:
					if (rd_go && adr_i == `SMST_A_DATA)
					begin
						rd_ptr_reg <= rd_ptr_reg + 8'h01;
						if (rd_ptr_reg == 8'hFF)
						begin
							drq_reg   <= 1'b0;
							state_reg <= SMST_IDLE;
						end
					end
				SMST_APPLY:
				begin
					state_reg    <= SMST_IDLE;
					irq_pend_reg <= 1'b1;
				end
				default:
					state_reg <= SMST_IDLE;
			endcase
		end
	end

	// Interrupt follows BSY release; reading status or a new command clears
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			intrq_reg <= 1'b0;
		else if (irq_pend_reg)
			intrq_reg <= 1'b1;
		else if ((rd_go || wr_go) && adr_i == `SMST_A_CMD)
			intrq_reg <= 1'b0;
	end

	// Setting from the store is taken once the synchroniser has settled
	always_ff @(posedge clk_i)
	begin
		nv_s1_reg <= nv_autosave_i;
		nv_s2_reg <= nv_s1_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			nv_cnt_reg <= 2'd0;
			asave_reg  <= 1'b0;
			nv_wr_reg  <= 1'b0;
		end
		else
		begin
			nv_wr_reg <= 1'b0;
			if (nv_cnt_reg != `SMST_NV_SETTLE)
			begin
				nv_cnt_reg <= nv_cnt_reg + 2'd1;
				asave_reg  <= nv_s2_reg;
			end
			else if (state_reg == SMST_APPLY
				&& (scnt_reg == `SMST_AS_ON || scnt_reg == `SMST_AS_OFF))
			begin
				asave_reg <= scnt_reg == `SMST_AS_ON;
				nv_wr_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			save_reg <= 1'b0;
		else
			save_reg <= (mode_change_i && asave_reg)
				|| normal_save_i;
	end

	assign ack_o       = ack_reg;
	assign dat_o       = dat_reg;
	assign intrq_o     = intrq_reg;
	assign attr_save_o = save_reg;
	assign nv_o.wr     = nv_wr_reg;
	assign nv_o.val    = asave_reg;
endmodule
`default_nettype wire

// *** smst_defs.svh ***
// Offsets, field positions, codes and fixed page values of the status logic
// Notes on behaviour
// - Low nibble of self-test byte gives remaining tenths, limited to 0..9.
// - High nibble gives execution code, 15 while running, never 8..14.
// - Codes 0 success, 1 host abort, 2 reset interrupt, 3 fatal error.
// - Failed test codes 4 unknown, 5 write, 6 servo, 7 read.
// - Bytes 364..365 hold total off-line collection time in seconds.
// - Capability byte sets bits 0,1,3,4,6 and clears bits 5,7.
// - Capability bit 2 tells abort (1) or suspend and resume (0).
// - Capability word bit 0 save before power change, bit 1 one.
// - Byte 371 holds checkpoint of the last failing self-test.
// - Bytes 374..510 reserved, byte 511 checksum of preceding bytes.
// - Thresholds read with feature D1h, signature C24Fh, 512 bytes.
// - Threshold read: BSY, fill buffer, DRQ, drop BSY, interrupt.
// - Threshold page: revision 0010h, thirty entries, reserved, checksum.
// - Entry of 12 bytes: identifier, threshold, ten reserved bytes.
// - Threshold 00h always passed, 01h..FDh valid, FEh/FFh unused.
// - Feature D2h: count F1h enables, zero disables, else unchanged.
// - Autosave setting kept in non-volatile store across power cycles.
// - With autosave on, attributes are saved on each mode transition.
// - Other normal save operations still save with autosave off.
// - Autosave command: BSY, apply setting, drop BSY, then interrupt.
// - Feature D0h returns data page with the same handshake.
// - Bytes 0..1 of data page carry revision 0010h.
`ifndef SMST_DEFS_SVH
`define SMST_DEFS_SVH
`define SMST_A_DATA     8'h00
`define SMST_A_FEAT     8'h04
`define SMST_A_SCNT     8'h08
`define SMST_A_SNUM     8'h0C
`define SMST_A_TRKL     8'h10
`define SMST_A_TRKH     8'h14
`define SMST_A_UNIT     8'h18
`define SMST_A_CMD      8'h1C
`define SMST_A_TEST     8'h20
`define SMST_A_OFFL     8'h24
`define SMST_A_TTIME    8'h28
`define SMST_A_CHKPT    8'h2C
`define SMST_A_POLL     8'h30
`define SMST_A_CAPS     8'h34
`define SMST_A_ASAVE    8'h38
`define SMST_A_THR0     8'h40
`define SMST_A_THRN     8'hB4
`define SMST_OPC        8'hB0
`define SMST_F_RDATA    8'hD0
`define SMST_F_RTHR     8'hD1
`define SMST_F_ASAVE    8'hD2
`define SMST_SIG_H      8'hC2
`define SMST_SIG_L      8'h4F
`define SMST_AS_ON      8'hF1
`define SMST_AS_OFF     8'h00
`define SMST_REV_LO     8'h10
`define SMST_REV_HI     8'h00
`define SMST_CODE_RUN   4'hF
`define SMST_CODE_FATAL 4'h3
`define SMST_CODE_MAXOK 4'h7
`define SMST_REM_MAX    4'h9
`define SMST_CAP_FIXED  8'h5B
`define SMST_CAP_BIT2   2
`define SMST_SCAP_FIXED 8'h02
`define SMST_ERRLOG     8'h01
`define SMST_B_ENT0     9'd2
`define SMST_B_ENTN     9'd361
`define SMST_B_OFFL     9'd362
`define SMST_B_TEST     9'd363
`define SMST_B_TTL      9'd364
`define SMST_B_TTH      9'd365
`define SMST_B_CAP      9'd367
`define SMST_B_SCAP     9'd368
`define SMST_B_ELOG     9'd370
`define SMST_B_CHK      9'd371
`define SMST_B_PSHORT   9'd372
`define SMST_B_PEXT     9'd373
`define SMST_B_LAST     9'd511
`define SMST_ENT_LEN    4'd11
`define SMST_N_ENT      30
`define SMST_ABRT_BIT   2
`define SMST_NV_SETTLE  2'd3
`endif

// *** smst_pkg.sv ***
// Types shared by the status and threshold logic
`default_nettype none
package smst_pkg;
	typedef enum logic [2:0] {
		SMST_IDLE,
		SMST_FILL,
		SMST_XFER,
		SMST_APPLY
	} smst_state_t;

	// Task-file status byte
	typedef struct packed {
		logic       busy;
		logic       ready;
		logic [1:0] rsvd_hi;
		logic       drq;
		logic [1:0] rsvd_lo;
		logic       err;
	} smst_status_t;

	// Non-volatile store write request
	typedef struct packed {
		logic wr;
		logic val;
	} smst_nv_t;
endpackage
`default_nettype wire

// *** smst_nv_model.sv ***
// Non-volatile autosave store on the far side of the status logic
`timescale 1ns/1ps
`default_nettype none
module smst_nv_model
#(
	parameter logic INIT = 1'b0
)
(
	input  wire logic               clk_i,
	input  wire smst_pkg::smst_nv_t nv_i,
	output var  logic               nv_autosave_o
);
	import smst_pkg::*;
	// No reset: the value must outlive drive resets
	initial nv_autosave_o = INIT;
	always @(posedge clk_i)
		if (nv_i.wr === 1'b1)
			nv_autosave_o <= nv_i.val;
endmodule
`default_nettype wire

// *** smst_core_checker.sv ***
// Port-level assertions for the status and threshold logic
`timescale 1ns/1ps
`default_nettype none
`include "smst_defs.svh"
module smst_core_checker
(
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic               cyc_i,
	input wire logic               stb_i,
	input wire logic               we_i,
	input wire logic [7:0]         adr_i,
	input wire logic [3:0]         sel_i,
	input wire logic [31:0]        dat_i,
	input wire logic [31:0]        dat_o,
	input wire logic               ack_o,
	input wire logic               intrq_o,
	input wire logic               mode_change_i,
	input wire logic               normal_save_i,
	input wire logic               attr_save_o,
	input wire logic               nv_autosave_i,
	input wire smst_pkg::smst_nv_t nv_o
);
	import smst_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_test_rd;
		ack_o && !we_i && adr_i == `SMST_A_TEST;
	endsequence
	sequence s_cmd;
		ack_o && we_i && adr_i == `SMST_A_CMD && dat_i[7:0] == `SMST_OPC;
	endsequence
	a_remain_limit: assert property (
		s_test_rd |-> dat_o[3:0] <= `SMST_REM_MAX)
		else $error("remaining tenths above nine");
	a_code_legal: assert property (
		s_test_rd |-> !(dat_o[7:4] inside {[4'h8:4'hE]}))
		else $error("reserved self-test code");
	a_mode_save: assert property (
		mode_change_i && nv_o.val |=> attr_save_o)
		else $error("no save on mode change");
	a_normal_save: assert property (
		normal_save_i |=> attr_save_o)
		else $error("no save on normal save");
	a_save_cause: assert property (
		attr_save_o |-> $past(normal_save_i) ||
			$past(mode_change_i && nv_o.val))
		else $error("save without cause");
	a_nv_pulse: assert property (
		nv_o.wr |=> !nv_o.wr)
		else $error("store write longer than one cycle");
	a_asave_read: assert property (
		ack_o && !we_i && adr_i == `SMST_A_ASAVE |-> dat_o[0] == nv_o.val)
		else $error("autosave state read mismatch");
	a_cmd_clears: assert property (
		s_cmd |=> !intrq_o)
		else $error("interrupt before busy release");
	a_irq_bounded: assert property (
		s_cmd |-> ##[1:600] intrq_o)
		else $error("command never completed");
endmodule
bind smst_core smst_core_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.intrq_o(intrq_o), .mode_change_i(mode_change_i),
	.normal_save_i(normal_save_i), .attr_save_o(attr_save_o),
	.nv_autosave_i(nv_autosave_i), .nv_o(nv_o));
`default_nettype wire

// *** test_smart_status_and_threshold_logic.sv ***
// Self-checking bench for the status and threshold logic
`timescale 1ns/1ps
`default_nettype none
`include "smst_defs.svh"
module test_smart_status_and_threshold_logic;
	import smst_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [3:0]  sel_i = 4'hF;
	logic [31:0] dat_i = 32'h0;
	logic        mode_change_i = 1'b0;
	logic        normal_save_i = 1'b0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        intrq_o;
	logic        attr_save_o;
	logic        nv_autosave_i;
	smst_nv_t    nv_o;
	int          mismatches = 0;
	int          n_compared = 0;
	int          seed = 88;
	logic [31:0] qe[$];
	logic [31:0] qm[$];
	logic [15:0] ew[256];
	logic [15:0] mw[256];
	logic [7:0]  th[30];
	logic [7:0]  psum;
	logic [15:0] tt;

	initial forever #5 clk_i = ~clk_i;

	smst_core u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .intrq_o(intrq_o),
		.mode_change_i(mode_change_i), .normal_save_i(normal_save_i),
		.attr_save_o(attr_save_o), .nv_autosave_i(nv_autosave_i),
		.nv_o(nv_o));
	smst_nv_model u_nv (.clk_i(clk_i), .nv_i(nv_o),
		.nv_autosave_o(nv_autosave_i));

	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Read results come back in order, so oldest note matches
	always @(posedge clk_i)
		if (ack_o === 1'b1 && we_i === 1'b0 && qe.size() > 0)
		begin
			chk(dat_o & qm[0], qe[0]);
			if (adr_i == `SMST_A_DATA)
				psum = psum + dat_o[7:0] + dat_o[15:8];
			void'(qe.pop_front());
			void'(qm.pop_front());
		end

	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge clk_i);
		while (ack_o !== 1'b1);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m);
		qe.push_back(e & m);
		qm.push_back(m);
		wb(1'b0, a, 32'h0);
	endtask

	task automatic cmd(input logic [7:0] f);
		int n;
		wb(1'b1, `SMST_A_FEAT, {24'h0, f});
		wb(1'b1, `SMST_A_CMD, {24'h0, `SMST_OPC});
		n = 0;
		while (intrq_o !== 1'b1 && n < 2000)
		begin
			@(posedge clk_i);
			n++;
		end
		chk({31'h0, intrq_o}, 32'h1);
	endtask

	task automatic pulse(input logic mc);
		@(posedge clk_i);
		mode_change_i <= mc;
		normal_save_i <= !mc;
		@(posedge clk_i);
		mode_change_i <= 1'b0;
		normal_save_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic clr;
		for (int i = 0; i < 256; i++)
		begin
			ew[i] = 16'h0;
			mw[i] = 16'hFFFF;
		end
		mw[255] = 16'h00FF;
		ew[0] = 16'h0010;
	endtask

	task automatic page(input logic [7:0] f);
		psum = 8'h00;
		cmd(f);
		rd(`SMST_A_CMD, 32'h08, 32'h89);
		for (int i = 0; i < 256; i++)
			rd(`SMST_A_DATA, {16'h0, ew[i]}, {16'h0, mw[i]});
		@(posedge clk_i);
		chk({24'h0, psum}, 32'h0);
	endtask

	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(`SMST_A_ASAVE, 32'h0, 32'h1);
		for (int c = 0; c < 16; c++)
		begin
			wb(1'b1, `SMST_A_TEST, {24'h0, 4'(c), 4'hC});
			rd(`SMST_A_TEST, c == 15 ? 32'hF9 : c > 7 ? 32'h30 :
				{24'h0, 4'(c), 4'h0}, 32'hFF);
		end
		// Write without the low byte lane must be ignored
		sel_i <= 4'hE;
		wb(1'b1, `SMST_A_TEST, 32'h12);
		sel_i <= 4'hF;
		rd(`SMST_A_TEST, 32'hF9, 32'hFF);
		$display("self-test status test done");
		clr();
		for (int k = 0; k < 30; k++)
		begin
			th[k] = k == 28 ? 8'h00 : k == 29 ? 8'hFE :
				8'h01 + 8'($unsigned($random(seed)) % 253);
			wb(1'b1, `SMST_A_THR0 + 8'(4 * k), {16'h0, th[k], 8'(k + 1)});
			ew[1 + 6 * k] = {th[k], 8'(k + 1)};
		end
		wb(1'b1, `SMST_A_TRKL, {24'h0, `SMST_SIG_L});
		wb(1'b1, `SMST_A_TRKH, {24'h0, `SMST_SIG_H});
		page(`SMST_F_RTHR);
		$display("threshold page test done");
		tt = 16'($random(seed));
		wb(1'b1, `SMST_A_TEST, 32'hF5);
		wb(1'b1, `SMST_A_OFFL, 32'h82);
		wb(1'b1, `SMST_A_TTIME, {16'h0, tt});
		wb(1'b1, `SMST_A_CHKPT, 32'h37);
		wb(1'b1, `SMST_A_POLL, 32'h2A05);
		wb(1'b1, `SMST_A_CAPS, 32'h3);
		clr();
		ew[181] = 16'hF582;
		ew[182] = tt;
		ew[183] = 16'h5F00;
		ew[184] = 16'h0003;
		ew[185] = 16'h3701;
		ew[186] = 16'h2A05;
		page(`SMST_F_RDATA);
		$display("data page test done");
		// Bad signature must abort without busy or data
		wb(1'b1, `SMST_A_TRKH, 32'hC3);
		cmd(`SMST_F_RTHR);
		rd(`SMST_A_CMD, 32'h01, 32'h89);
		rd(`SMST_A_FEAT, 32'h04, 32'h04);
		wb(1'b1, `SMST_A_TRKH, {24'h0, `SMST_SIG_H});
		// Unknown feature code with a good signature is refused too
		cmd(8'hD3);
		rd(`SMST_A_CMD, 32'h01, 32'h89);
		$display("signature test done");
		for (int i = 0; i < 3; i++)
		begin
			wb(1'b1, `SMST_A_SCNT, i == 0 ? 32'hF1 : i == 1 ? 32'h05 : 32'h0);
			cmd(`SMST_F_ASAVE);
			rd(`SMST_A_CMD, 32'h0, 32'h80);
			rd(`SMST_A_ASAVE, i < 2, 32'h1);
			pulse(1'b1);
			chk({31'h0, attr_save_o}, i < 2);
			pulse(1'b0);
			chk({31'h0, attr_save_o}, 32'h1);
		end
		wb(1'b1, `SMST_A_SCNT, 32'hF1);
		cmd(`SMST_F_ASAVE);
		rd(`SMST_A_CMD, 32'h0, 32'h80);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		rd(`SMST_A_ASAVE, 32'h1, 32'h1);
		$display("autosave test done");
		repeat (2) @(posedge clk_i);
		complete_run();
	end

	initial
	begin
		repeat (30000) @(posedge clk_i);
		mismatches++;
		complete_run();
	end
endmodule
`default_nettype wire
